// File: pkg/fsq_pkg.sv
/*
 * fsq_pkg: shared constants and types for the fir filter sequencer and its
 * host-side loader.
 * assumes: one clock domain, both ends compiled against the same package.
 */
package fsq_pkg;

  // ****************************************
  // program space
  // ****************************************
  localparam int FSQ_STEPS = 32;
  localparam int FSQ_STEP_W = 5;
  localparam int FSQ_WORD_W = 128;
  localparam int FSQ_QTR_W = 32;
  localparam logic [4:0] FSQ_LAST_STEP = 5'h1F;

  // ****************************************
  // indirect address layout: chan(4) | 00010 | step(5) | sel(2)
  // ****************************************
  localparam int FSQ_ADDR_W = 16;
  localparam int FSQ_CHAN_LSB = 12;
  localparam int FSQ_FIX_LSB = 7;
  localparam logic [4:0] FSQ_FIX_PAT = 5'h02;
  localparam int FSQ_STEP_LSB = 2;
  localparam int FSQ_SEL_LSB = 0;

  // ****************************************
  // instruction field positions
  // ****************************************
  localparam int FSQ_OP_W = 9;
  localparam int FSQ_JUMP_BIT = 8;
  localparam int FSQ_FIR_BIT = 7;
  localparam int FSQ_COND_LSB = 0;
  localparam int FSQ_DEST_LSB = 3;
  localparam int FSQ_LDLP_BIT = 2;
  localparam int FSQ_DECLP_BIT = 1;
  localparam int FSQ_SYM_BIT = 9;
  localparam int FSQ_HB_BIT = 10;
  localparam int FSQ_TAPS_LSB = 16;
  localparam int FSQ_TAPS_W = 8;
  localparam int FSQ_NIN_LSB = 24;
  localparam int FSQ_NIN_W = 4;
  localparam int FSQ_OFS_BIT = 28;
  localparam int FSQ_LOOP_LSB = 32;
  localparam int FSQ_LOOP_W = 8;

  // ****************************************
  // conditions and data widths
  // ****************************************
  localparam logic [2:0] FSQ_C_LT = 3'h0;
  localparam logic [2:0] FSQ_C_GE = 3'h1;
  localparam logic [2:0] FSQ_C_LPZ = 3'h2;
  localparam logic [2:0] FSQ_C_LPNZ = 3'h3;
  localparam logic [2:0] FSQ_C_ALWAYS = 3'h7;
  localparam int FSQ_THR_W = 10;
  localparam int FSQ_PTR_W = 8;
  localparam int FSQ_CHAN_W = 4;
  localparam int FSQ_CHANS = 4;
  localparam logic [3:0] FSQ_GAIN_SRC = 4'h3;

  typedef enum logic [3:0] {
    FSQ_FETCH = 4'b0001,
    FSQ_WRITE = 4'b0010,
    FSQ_COMP = 4'b0100,
    FSQ_HOLD = 4'b1000
  } fsq_state_type;

  typedef enum logic [2:0] {
    FSQ_H_IDLE = 3'b001,
    FSQ_H_SEND = 3'b010,
    FSQ_H_DONE = 3'b100
  } fsq_hstate_type;

  // symmetric steps: two taps per clock; halfband 19 taps -> 6 clocks
  function automatic logic [7:0] fsq_cycles(input logic [7:0] taps, input logic sym,
                                          input logic hb);
    logic [7:0] half;
    half = 8'((taps + 8'h01) >> 1);
    if (hb) begin
      // halfband: every other tap is zero, so pairs of pairs plus one centre clock
      fsq_cycles = 8'((half + 8'h01) >> 1) + 8'h01;
    end else if (sym) begin
      fsq_cycles = half;
    end else begin
      fsq_cycles = taps;
    end
    if (fsq_cycles == 8'h00) begin
      fsq_cycles = 8'h01;
    end
  endfunction : fsq_cycles

  function automatic logic [15:0] fsq_addr(input logic [3:0] chan, input logic [4:0] step,
                                         input logic [1:0] sel);
    fsq_addr = {chan, FSQ_FIX_PAT, step, sel};
  endfunction : fsq_addr

endpackage : fsq_pkg

// File: pkg/fsq_if.sv
/*
 * fsq_if: host read and write port into the sequencer's instruction store plus the
 * hold and filter reset controls.
 * assumes: both ends share clk.
 */
`timescale 1ns/100ps
`default_nettype none
interface fsq_if (input wire logic clk);
  import fsq_pkg::*;
  logic host_memory_access_hold;
  logic filter_reset;
  logic wr_en;
  logic rd_en;
  logic [15:0] indirect_word_location;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic access_refused;

  modport dev (input host_memory_access_hold, filter_reset, wr_en, rd_en,
               indirect_word_location, wr_data, output rd_data, access_refused);
  modport host (output host_memory_access_hold, filter_reset, wr_en, rd_en,
                indirect_word_location, wr_data, input rd_data, access_refused);
endinterface : fsq_if
`default_nettype wire

// File: design/fsq_sequencer.sv
/*
 * fsq_sequencer: program store and step sequencer for one channel's fir
 * compute engine, with cycle budgeting, polyphase offset and gain routing.
 * assumes: host end drives fsq_if.host synchronously to clk.
 */
// Contract
// - up to 32 steps, 5-bit index
// - step is fir or flow control
// - each step is a 128-bit word
// - low nine bits hold the opcode
// - host loads step in four writes
// - address: channel, 00010, step, select
// - filter reset points to step 31
// - filter reset clears data pointers
// - host resets on channel start
// - memory access only under hold
// - fixed read offset on one step
// - polyphase channels write same location
// - channels offset by one sample
// - polyphase outputs interleave in formatter
// - channel 4 gain may drive all
// - gain never shared across devices
// - symmetric step does two taps/clock
// - 19-tap halfband takes six clocks
// - one clock per input write
// - wait and jump take one clock
// - wait compares count with 10-bit threshold
// - one step per filter stage
`timescale 1ns/100ps
`default_nettype none
module fsq_sequencer
  import fsq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  fsq_if.dev bus,
  input wire logic [3:0] my_chan,
  input wire logic [9:0] wait_threshold,
  input wire logic [7:0] read_offset,
  input wire logic [1:0] phase_index,
  input wire logic sample_in_valid,
  input wire logic gain_share_en,
  input wire logic [15:0] own_gain,
  input wire logic [15:0] chan4_gain,
  output logic [4:0] step_ptr,
  output logic [8:0] op_code,
  output logic compute_busy,
  output logic output_strobe,
  output logic [1:0] output_slot,
  output logic [7:0] wr_ptr,
  output logic [7:0] rd_start,
  output logic [15:0] gain_used,
  output logic gain_update
);

  // ****************************************
  // instruction store
  // ****************************************
  // store
  logic [127:0] prog_mem [FSQ_STEPS];
  logic [31:0] rd_data_q;
  logic refused_q;
  logic [3:0] a_chan;
  logic [4:0] a_pat;
  logic [4:0] a_step;
  logic [1:0] a_sel;
  logic a_hit;

  always_comb begin
    a_chan = bus.indirect_word_location[15:12];
    a_pat = bus.indirect_word_location[11:7];
    a_step = bus.indirect_word_location[6:2];
    a_sel = bus.indirect_word_location[1:0];
    a_hit = (a_chan == my_chan) && (a_pat == FSQ_FIX_PAT);
  end

  always_ff @(posedge clk) begin
    if (bus.wr_en && a_hit && bus.host_memory_access_hold) begin
      prog_mem[a_step][a_sel*32 +: 32] <= bus.wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= 32'h0000_0000;
      refused_q <= 1'b0;
    end else begin
      refused_q <= (bus.wr_en || bus.rd_en) && a_hit && !bus.host_memory_access_hold;
      if (bus.rd_en && a_hit && bus.host_memory_access_hold) begin
        rd_data_q <= prog_mem[a_step][a_sel*32 +: 32];
      end
    end
  end
  assign bus.rd_data = rd_data_q;
  assign bus.access_refused = refused_q;

  // ****************************************
  // sequencer
  // ****************************************
  fsq_state_type state, next_state;
  logic [4:0] next_step_ptr;
  logic [7:0] cnt, next_cnt;
  logic [3:0] nin, next_nin;
  logic [9:0] avail, next_avail;
  logic [7:0] loop_cnt, next_loop_cnt;
  logic [7:0] next_wr_ptr, next_rd_start;
  logic next_busy, next_strobe;
  logic [8:0] next_op;
  logic [1:0] next_slot;
  logic [127:0] ins;
  logic cond_ok;

  always_comb begin
    ins = prog_mem[step_ptr];
    unique case (ins[2:0])
      FSQ_C_LT: cond_ok = avail < wait_threshold;
      FSQ_C_GE: cond_ok = avail >= wait_threshold;
      FSQ_C_LPZ: cond_ok = loop_cnt == 8'h00;
      FSQ_C_LPNZ: cond_ok = loop_cnt != 8'h00;
      default: cond_ok = 1'b1;
    endcase
  end

  always_comb begin
    next_state = state;
    next_step_ptr = step_ptr;
    next_cnt = cnt;
    next_nin = nin;
    next_avail = avail + {9'h000, sample_in_valid};
    next_loop_cnt = loop_cnt;
    next_wr_ptr = wr_ptr;
    next_rd_start = rd_start;
    next_busy = 1'b0;
    next_strobe = 1'b0;
    next_op = op_code;
    next_slot = output_slot;
    unique case (state)
      FSQ_HOLD: begin
        if (!bus.host_memory_access_hold) begin
          next_state = FSQ_FETCH;
        end
      end
      FSQ_FETCH: begin
        next_op = ins[8:0];
        next_busy = 1'b1;
        if (bus.host_memory_access_hold) begin
          next_state = FSQ_HOLD;
          next_busy = 1'b0;
        end else if (ins[FSQ_JUMP_BIT]) begin
          next_step_ptr = cond_ok ? ins[7:3] : 5'(step_ptr + 5'h01);
        end else if (!ins[FSQ_FIR_BIT]) begin
          // wait holds while true; one clock per check
          if (!cond_ok) begin
            next_step_ptr = 5'(step_ptr + 5'h01);
          end
        end else begin
          if (ins[FSQ_LDLP_BIT]) begin
            next_loop_cnt = ins[FSQ_LOOP_LSB +: FSQ_LOOP_W];
          end else if (ins[FSQ_DECLP_BIT] && loop_cnt != 8'h00) begin
            next_loop_cnt = 8'(loop_cnt - 8'h01);
          end
          // phase shifts start by one sample
          next_rd_start = ins[FSQ_OFS_BIT] ?
            8'(wr_ptr - read_offset - {6'h00, phase_index}) : wr_ptr;
          next_nin = ins[FSQ_NIN_LSB +: FSQ_NIN_W];
          next_cnt = fsq_cycles(ins[FSQ_TAPS_LSB +: FSQ_TAPS_W], ins[FSQ_SYM_BIT],
                                ins[FSQ_HB_BIT]);
          if (ins[FSQ_TAPS_LSB +: FSQ_TAPS_W] == 8'h00) begin
            // no-op
            next_step_ptr = 5'(step_ptr + 5'h01);
          end else if (next_nin != 4'h0) begin
            next_state = FSQ_WRITE;
          end else begin
            next_state = FSQ_COMP;
          end
        end
      end
      FSQ_WRITE: begin
        next_busy = 1'b1;
        // one write per sample, shared location
        next_wr_ptr = 8'(wr_ptr + 8'h01);
        if (avail != 10'h000) begin
          next_avail = avail - 10'h001 + {9'h000, sample_in_valid};
        end
        next_nin = 4'(nin - 4'h1);
        if (nin == 4'h1) begin
          next_state = FSQ_COMP;
        end
      end
      FSQ_COMP: begin
        next_busy = 1'b1;
        next_cnt = 8'(cnt - 8'h01);
        if (cnt == 8'h01) begin
          next_strobe = 1'b1;
          next_slot = phase_index;
          next_step_ptr = 5'(step_ptr + 5'h01);
          next_state = FSQ_FETCH;
        end
      end
      default: next_state = FSQ_FETCH;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= FSQ_FETCH;
      step_ptr <= FSQ_LAST_STEP;
      cnt <= 8'h00;
      nin <= 4'h0;
      avail <= 10'h000;
      loop_cnt <= 8'h00;
      wr_ptr <= 8'h00;
      rd_start <= 8'h00;
      compute_busy <= 1'b0;
      output_strobe <= 1'b0;
      op_code <= 9'h000;
      output_slot <= 2'h0;
    end else if (bus.filter_reset) begin
      state <= FSQ_FETCH;
      step_ptr <= FSQ_LAST_STEP;
      cnt <= 8'h00;
      nin <= 4'h0;
      avail <= 10'h000;
      loop_cnt <= 8'h00;
      wr_ptr <= 8'h00;
      rd_start <= 8'h00;
      compute_busy <= 1'b0;
      output_strobe <= 1'b0;
      op_code <= 9'h000;
      output_slot <= 2'h0;
    end else begin
      state <= next_state;
      step_ptr <= next_step_ptr;
      cnt <= next_cnt;
      nin <= next_nin;
      avail <= next_avail;
      loop_cnt <= next_loop_cnt;
      wr_ptr <= next_wr_ptr;
      rd_start <= next_rd_start;
      compute_busy <= next_busy;
      output_strobe <= next_strobe;
      op_code <= next_op;
      output_slot <= next_slot;
    end
  end

  // ****************************************
  // gain routing
  // ****************************************
  // on-chip only; shared gain updates on slot-3 outputs, own gain on every output
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_used <= 16'h0000;
      gain_update <= 1'b0;
    end else begin
      gain_update <= next_strobe && (!gain_share_en || next_slot == 2'h3);
      gain_used <= gain_share_en ? chan4_gain : own_gain;
    end
  end

endmodule : fsq_sequencer
`default_nettype wire

// File: design/fsq_host.sv
/*
 * fsq_host: host-side loader that writes one 128-bit program step as four
 * quarter writes under hold, and pulses filter reset on start.
 * assumes: device samples the fsq_if signals on the same clk.
 */
`timescale 1ns/100ps
`default_nettype none
module fsq_host
  import fsq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  fsq_if.host bus,
  input wire logic load_req,
  input wire logic [3:0] load_chan,
  input wire logic [4:0] load_step,
  input wire logic [127:0] load_word,
  input wire logic restart_req,
  output logic load_done
);

  fsq_hstate_type hs, next_hs;
  logic [1:0] sel, next_sel;
  logic [127:0] word, next_word;
  logic [15:0] addr, next_addr;
  logic hold, next_hold, rst_p, next_rst_p, done, next_done, wr, next_wr;
  logic [31:0] wdat, next_wdat;

  always_comb begin
    next_hs = hs;
    next_sel = sel;
    next_word = word;
    next_addr = addr;
    next_hold = hold;
    next_wr = 1'b0;
    next_wdat = wdat;
    next_done = 1'b0;
    next_rst_p = restart_req;
    unique case (hs)
      FSQ_H_IDLE: begin
        if (load_req) begin
          next_hold = 1'b1;
          next_word = load_word;
          next_sel = 2'h0;
          next_hs = FSQ_H_SEND;
        end
      end
      FSQ_H_SEND: begin
        next_wr = 1'b1;
        next_addr = fsq_addr(load_chan, load_step, sel);
        next_wdat = word[sel*32 +: 32];
        next_sel = 2'(sel + 2'h1);
        if (sel == 2'h3) begin
          next_hs = FSQ_H_DONE;
        end
      end
      FSQ_H_DONE: begin
        next_hold = 1'b0;
        next_done = 1'b1;
        next_hs = FSQ_H_IDLE;
      end
      default: next_hs = FSQ_H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hs <= FSQ_H_IDLE;
      sel <= 2'h0;
      word <= 128'h0;
      addr <= 16'h0000;
      hold <= 1'b0;
      wr <= 1'b0;
      wdat <= 32'h0000_0000;
      done <= 1'b0;
      rst_p <= 1'b0;
    end else begin
      hs <= next_hs;
      sel <= next_sel;
      word <= next_word;
      addr <= next_addr;
      hold <= next_hold;
      wr <= next_wr;
      wdat <= next_wdat;
      done <= next_done;
      rst_p <= next_rst_p;
    end
  end

  assign bus.host_memory_access_hold = hold;
  assign bus.filter_reset = rst_p;
  assign bus.wr_en = wr;
  assign bus.rd_en = 1'b0;
  assign bus.indirect_word_location = addr;
  assign bus.wr_data = wdat;
  assign load_done = done;

endmodule : fsq_host
`default_nettype wire

// File: test/fsq_seq_properties.sv
/*
 * fsq_seq_properties: concurrent checks on the port joining fsq_host and fsq_sequencer.
 * assumes: instantiated beside that fsq_if, fed its signals and the shared clk and rst_b.
 */
`timescale 1ns/100ps
`default_nettype none
module fsq_seq_properties
  import fsq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic host_memory_access_hold,
  input wire logic filter_reset,
  input wire logic wr_en,
  input wire logic [15:0] indirect_word_location,
  input wire logic access_refused
);
  // ****************************************
  // port checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [1:0] sel;
  assign sel = indirect_word_location[1:0];

  property p_wr_hold; wr_en |-> host_memory_access_hold; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write without hold");
  property p_fix_pat; wr_en |-> indirect_word_location[11:7] == 5'h02; endproperty
  a_fix_pat: assert property (p_fix_pat) else $error("bad fixed address pattern");
  property p_quarters;
    wr_en && sel == 2'h0 |=> wr_en && sel == 2'h1 ##1 wr_en && sel == 2'h2 ##1 wr_en && sel == 2'h3;
  endproperty
  a_quarters: assert property (p_quarters) else $error("quarter writes out of order");
  property p_same_step; wr_en && sel != 2'h0 |-> $stable(indirect_word_location[15:2]); endproperty
  a_same_step: assert property (p_same_step) else $error("step moved within a load");
  property p_no_refuse; !access_refused; endproperty
  a_no_refuse: assert property (p_no_refuse) else $error("loader access refused");
  property p_hold_lead; $rose(host_memory_access_hold) |=> wr_en && sel == 2'h0; endproperty
  a_hold_lead: assert property (p_hold_lead) else $error("hold not one cycle ahead");
  property p_hold_tail; wr_en && sel == 2'h3 |=> !wr_en && !host_memory_access_hold; endproperty
  a_hold_tail: assert property (p_hold_tail) else $error("hold kept after last quarter");
  property p_reset_pulse; $rose(filter_reset) |=> !filter_reset; endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("filter reset too long");
endmodule : fsq_seq_properties
`default_nettype wire

// File: test/fsq_sequencer_tb.sv
/*
 * fsq_sequencer_tb: loader and sequencer joined on one fsq_if, plus a second
 * sequencer driven directly by the bench to provoke refused accesses.
 * assumes: fsq_pkg, fsq_if and both design ends compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module fsq_sequencer_tb;
  // ****************************************
  // stimulus and wiring
  // ****************************************
  logic clk = 1'b0;
  logic rst_b, load_req, restart_req, load_done, sample_in_valid, gain_share_en, output_strobe;
  logic [3:0] load_chan;
  logic [4:0] load_step, step_ptr;
  logic [127:0] load_word;
  logic [9:0] wait_threshold;
  logic [8:0] op_code;
  logic [7:0] wr_ptr, rd_start;
  logic [1:0] phase, output_slot;
  logic gain_update, compute_busy;
  logic [15:0] gain_used, own_g, c4_g;
  logic [31:0] rd_q;
  logic ref_q;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  // no-op at 31, wait, symmetric 30 taps with read offset, halfband 19 taps, jump to 0
  logic [4:0] idx [0:4] = '{5'h1F, 5'h00, 5'h01, 5'h02, 5'h03};
  logic [127:0] prog [0:4] = '{128'h80, 128'h0, {32'hC3A5_0000, 64'h0, 32'h111E_0280},
                               128'h0213_0480, 128'h107};
  always #10 clk = ~clk;

  fsq_if bus_a (.clk(clk));
  fsq_if bus_b (.clk(clk));
  fsq_host fsq_host_i (.clk(clk), .rst_b(rst_b), .bus(bus_a), .load_req(load_req),
    .load_chan(load_chan), .load_step(load_step), .load_word(load_word),
    .restart_req(restart_req), .load_done(load_done));
  fsq_sequencer fsq_sequencer_i (.clk(clk), .rst_b(rst_b), .bus(bus_a), .my_chan(4'h3),
    .wait_threshold(wait_threshold), .read_offset(8'h04), .phase_index(phase),
    .sample_in_valid(sample_in_valid), .gain_share_en(gain_share_en), .own_gain(own_g),
    .chan4_gain(c4_g), .step_ptr(step_ptr), .op_code(op_code),
    .compute_busy(compute_busy), .output_strobe(output_strobe),
    .output_slot(output_slot), .wr_ptr(wr_ptr), .rd_start(rd_start),
    .gain_used(gain_used), .gain_update(gain_update));
  // second copy only answers the bench's direct accesses
  fsq_sequencer fsq_sequencer_i2 (.clk(clk), .rst_b(rst_b), .bus(bus_b), .my_chan(4'h5),
    .wait_threshold(wait_threshold), .read_offset(8'h04), .phase_index(2'h0),
    .sample_in_valid(sample_in_valid), .gain_share_en(gain_share_en), .own_gain(own_g),
    .chan4_gain(c4_g), .step_ptr(), .op_code(), .compute_busy(), .output_strobe(),
    .output_slot(), .wr_ptr(), .rd_start(), .gain_used(), .gain_update());
  fsq_seq_properties fsq_seq_properties_i (.clk(clk), .rst_b(rst_b),
    .host_memory_access_hold(bus_a.host_memory_access_hold),
    .filter_reset(bus_a.filter_reset), .wr_en(bus_a.wr_en),
    .indirect_word_location(bus_a.indirect_word_location),
    .access_refused(bus_a.access_refused));

  // ****************************************
  // access tasks
  // ****************************************
  task wrap_up;
    $display("comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task load(input logic [4:0] s, input logic [127:0] w);
    int k;
    @(negedge clk);
    load_req = 1'b1;
    load_step = s;
    load_word = w;
    @(negedge clk);
    load_req = 1'b0;
    k = 1;
    do begin @(negedge clk); k++; end while (load_done !== 1'b1 && k < 20);
    `CHK(k, 6)
  endtask : load

  task dev_acc(input logic w, input logic h, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    bus_b.host_memory_access_hold = h;
    bus_b.wr_en = w;
    bus_b.rd_en = !w;
    bus_b.indirect_word_location = a;
    bus_b.wr_data = d;
    @(negedge clk);
    bus_b.wr_en = 1'b0;
    bus_b.rd_en = 1'b0;
    rd_q = bus_b.rd_data;
    ref_q = bus_b.access_refused;
  endtask : dev_acc

  // strobes are one cycle wide, so count edges from the previous one
  task wait_strobe(output int k);
    k = 0;
    do begin @(negedge clk); k++; end while (output_strobe !== 1'b1 && k < 200);
  endtask : wait_strobe

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rst_b = 1'b0; load_req = 1'b0; restart_req = 1'b0; load_chan = 4'h3;
    load_step = 5'h00; load_word = 128'h0; wait_threshold = 10'h002;
    sample_in_valid = 1'b0; gain_share_en = 1'b1; own_g = 16'h1234; c4_g = 16'hA5A5;
    phase = 2'h1;
    bus_b.host_memory_access_hold = 1'b0; bus_b.filter_reset = 1'b0; bus_b.wr_en = 1'b0;
    bus_b.rd_en = 1'b0; bus_b.indirect_word_location = 16'h0000; bus_b.wr_data = 32'h0;
    repeat (4) @(negedge clk);
    `CHK(step_ptr, 5'h1F)
    rst_b = 1'b1;
    for (int i = 0; i < 5; i++) load(idx[i], prog[i]);
    @(negedge clk) restart_req = 1'b1;
    @(negedge clk) restart_req = 1'b0;
    for (n = 0; n < 8 && bus_a.filter_reset !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    `CHK(step_ptr, 5'h1F)
    `CHK(wr_ptr, 8'h00)
    `CHK(compute_busy, 1'b0)
    for (n = 0; n < 8 && step_ptr !== 5'h00; n++) @(negedge clk);
    `CHK(step_ptr, 5'h00)
    // one sample stays below a threshold of two
    sample_in_valid = 1'b1;
    @(negedge clk) sample_in_valid = 1'b0;
    repeat (30) @(negedge clk);
    `CHK(step_ptr, 5'h00)
    sample_in_valid = 1'b1;
    wait_strobe(n);
    wait_strobe(n);
    `CHK(n, 9)
    `CHK(op_code, 9'h080)
    wait_strobe(n);
    `CHK(n, 19)
    // three samples written before this fetch, offset four, phase one
    `CHK(rd_start, 8'hFE)
    `CHK(output_slot, 2'h1)
    repeat (8) wait_strobe(n);
    `CHK(gain_used, 16'hA5A5)
    `CHK(gain_update, 1'b0)
    phase = 2'h3;
    wait_strobe(n);
    `CHK(gain_update, 1'b1)
    gain_share_en = 1'b0;
    repeat (8) wait_strobe(n);
    `CHK(gain_used, 16'h1234)
    `CHK(gain_update, 1'b1)
    sample_in_valid = 1'b0;
    for (int s = 0; s < 4; s++) begin
      dev_acc(1'b1, 1'b1, {4'h5, 5'h02, 5'h07, s[1:0]}, {4{4'hA, 2'b00, s[1:0]}});
    end
    for (int s = 0; s < 4; s++) begin
      dev_acc(1'b0, 1'b1, {4'h5, 5'h02, 5'h07, s[1:0]}, 32'h0);
      `CHK(rd_q, {4{4'hA, 2'b00, s[1:0]}})
      `CHK(ref_q, 1'b0)
    end
    dev_acc(1'b1, 1'b0, {4'h5, 5'h02, 5'h07, 2'h0}, 32'hFFFF_FFFF);
    `CHK(ref_q, 1'b1)
    dev_acc(1'b0, 1'b1, {4'h5, 5'h02, 5'h07, 2'h0}, 32'h0);
    `CHK(rd_q, 32'hA0A0_A0A0)
    wrap_up();
  end
endmodule : fsq_sequencer_tb
`default_nettype wire
